// *** design/asr_pkg.sv ***
// Shared constants and carriers for the serial receiver and its status logic.
// Assumes a single 20 MHz clock and software accesses delivered as one-cycle pulses.
package asr_pkg;

  // ==========================================================
  // Oversampling and frame
  localparam int SLOTS = 16;
  localparam logic [4:0] SLOT_FIRST = 5'h01;
  localparam logic [4:0] SLOT_LAST = 5'h10;
  localparam logic [4:0] SLOT_START_A = 5'h03;
  localparam logic [4:0] SLOT_START_B = 5'h05;
  localparam logic [4:0] SLOT_START_C = 5'h07;
  localparam logic [4:0] SLOT_BIT_A = 5'h08;
  localparam logic [4:0] SLOT_BIT_B = 5'h09;
  localparam logic [4:0] SLOT_BIT_C = 5'h0a;
  localparam logic [4:0] SLOT_EARLY = 5'h04;
  localparam logic [3:0] DATA_BITS8 = 4'h8;
  localparam logic [3:0] DATA_BITS9 = 4'h9;
  localparam int FRAME_BITS8 = 10;
  localparam int FRAME_BITS9 = 11;
  localparam logic [7:0] IDLE_TICKS8 = 8'(SLOTS * FRAME_BITS8);
  localparam logic [7:0] IDLE_TICKS9 = 8'(SLOTS * FRAME_BITS9);
  localparam logic [2:0] HIST_HIGH = 3'h7;

  // ==========================================================
  // Widths and reset values
  localparam int DIV_W = 13;
  localparam int CHAR_W = 9;
  localparam int FIFO_DEPTH = 16;
  localparam logic TX_EMPTY_RST = 1'b1;
  localparam logic TX_DONE_RST = 1'b1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } asr_char_t;

  typedef struct packed {
    logic full;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } asr_flags_t;

  typedef struct packed {
    logic rxFull;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
    logic txEmpty;
    logic txDone;
  } asr_irq_en_t;

endpackage : asr_pkg

// *** design/asr_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/10ps
module asr_fifo
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r, wrPtr_nxt;
  logic [AW:0] rdPtr_r, rdPtr_nxt;
  logic push, pop;

  always_comb
  begin
    inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
    outValid = wrPtr_r != rdPtr_r;
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
  end

  assign outData = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  // Storage needs no reset; empty pointers hide stale words
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_r[AW-1:0]] <= inData;
  end

endmodule : asr_fifo

// *** design/asr_receiver.sv ***
// Receive side of an asynchronous serial unit with its status flags and interrupt requests.
// Assumes software register accesses arrive as one-cycle pulses on the clk domain.
`timescale 1ns/10ps
module asr_receiver
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial line
  input wire logic serialIn,
  // Configuration
  input wire logic receiverOn,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic nineBitMode,
  input wire logic wakeAddrMark,
  input wire logic idleCountType,
  input wire logic parityOn,
  input wire logic parityOddSel,
  input wire asr_irq_en_t irqEnable,
  // Software accesses, one-cycle pulses
  input wire logic statusRead,
  input wire logic dataRead,
  input wire logic ninthRead,
  input wire logic sleepWrite,
  // Transmitter hooks
  input wire logic txDataWrite,
  input wire logic txShiftLoad,
  input wire logic txNinthBit,
  input wire logic txLineIdle,
  // Receive buffer and status
  output asr_char_t rxChar,
  output asr_flags_t rxFlags,
  output logic rxSleep,
  output logic txEmptyFlag,
  output logic txDoneFlag,
  output logic txShiftNinth,
  // Interrupt requests
  output logic txIrq,
  output logic rxIrq,
  output logic errIrq,
  // Received character stream
  output logic streamValid,
  input wire logic streamReady,
  output asr_char_t streamChar
);

  typedef enum logic [0:0] {ST_HUNT, ST_FRAME} asr_state_t;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  // ==========================================================
  // Input synchroniser and baud divider
  logic sync1_r, sync2_r;
  logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
  logic tick;

  always_comb
  begin
    tick = 1'b0;
    divCnt_nxt = '0;
    if (receiverOn && baudDivisor != '0)
    begin
      // Compare as at-or-above so a divisor lowered mid-count does not run the counter to wrap
      if (divCnt_r >= baudDivisor - 1'b1)
        tick = 1'b1;
      else
        divCnt_nxt = divCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      divCnt_r <= '0;
    end
    else
    begin
      sync1_r <= serialIn;
      sync2_r <= sync1_r;
      divCnt_r <= divCnt_nxt;
    end
  end

  // ==========================================================
  // Sampling and shifting
  asr_state_t state_r, state_nxt;
  logic [2:0] hist_r, hist_nxt;
  logic [4:0] slot_r, slot_nxt;
  logic [3:0] bitIdx_r, bitIdx_nxt;
  logic [2:0] vote_r, vote_nxt;
  logic [CHAR_W-1:0] shift_r, shift_nxt;
  logic noise_r, noise_nxt;
  logic [3:0] dataBits;
  logic smp, edgeSeen, bitVal, frameDone, frameStopBad, frameBreak;
  logic [4:0] slotNew;

  always_comb
  begin
    smp = sync2_r;
    dataBits = nineBitMode ? DATA_BITS9 : DATA_BITS8;
    state_nxt = state_r;
    hist_nxt = hist_r;
    slot_nxt = slot_r;
    bitIdx_nxt = bitIdx_r;
    vote_nxt = vote_r;
    shift_nxt = shift_r;
    noise_nxt = noise_r;
    edgeSeen = !smp && hist_r == HIST_HIGH;
    bitVal = majority({vote_r[1:0], smp});
    frameDone = 1'b0;
    frameStopBad = 1'b0;
    frameBreak = 1'b0;
    slotNew = (slot_r == SLOT_LAST) ? SLOT_FIRST : slot_r + 1'b1;
    if (!receiverOn)
    begin
      state_nxt = ST_HUNT;
      hist_nxt = '0;
    end
    else if (tick)
    begin
      hist_nxt = {hist_r[1:0], smp};
      unique case (state_r)
        ST_HUNT:
        begin
          if (edgeSeen)
          begin
            state_nxt = ST_FRAME;
            slot_nxt = SLOT_FIRST;
            bitIdx_nxt = '0;
            noise_nxt = 1'b0;
            shift_nxt = '0;
          end
        end
        ST_FRAME:
        begin
          // Realign only near bit boundaries so mid-bit glitches do not slip the frame
          if (edgeSeen && bitIdx_r != '0 && (slotNew > SLOT_BIT_C || slotNew < SLOT_EARLY))
            slotNew = SLOT_FIRST;
          slot_nxt = slotNew;
          if (bitIdx_r == '0)
          begin
            if (slotNew == SLOT_START_A)
              vote_nxt[0] = smp;
            else if (slotNew == SLOT_START_B)
              vote_nxt[1] = smp;
            else if (slotNew == SLOT_START_C)
            begin
              if (majority({vote_r[1:0], smp}))
                state_nxt = ST_HUNT;
              else if (vote_r[0] | vote_r[1] | smp)
                noise_nxt = 1'b1;
            end
            else if (slotNew >= SLOT_BIT_A && slotNew <= SLOT_BIT_C)
            begin
              // Start bit stays low whatever these samples show
              if (smp)
                noise_nxt = 1'b1;
              if (slotNew == SLOT_BIT_C)
                bitIdx_nxt = 4'h1;
            end
          end
          else if (slotNew == SLOT_BIT_A)
            vote_nxt[0] = smp;
          else if (slotNew == SLOT_BIT_B)
            vote_nxt[1] = smp;
          else if (slotNew == SLOT_BIT_C)
          begin
            if (!(vote_r[0] == smp && vote_r[1] == smp))
              noise_nxt = 1'b1;
            if (bitIdx_r <= dataBits)
            begin
              shift_nxt[bitIdx_r - 1'b1] = bitVal;
              bitIdx_nxt = bitIdx_r + 1'b1;
            end
            else
            begin
              frameDone = 1'b1;
              frameStopBad = !bitVal;
              frameBreak = !bitVal && shift_r == '0;
              state_nxt = ST_HUNT;
              if (frameStopBad && !frameBreak)
                hist_nxt = HIST_HIGH;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_HUNT;
      hist_r <= '0;
      slot_r <= SLOT_FIRST;
      bitIdx_r <= '0;
      vote_r <= '0;
      shift_r <= '0;
      noise_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hist_r <= hist_nxt;
      slot_r <= slot_nxt;
      bitIdx_r <= bitIdx_nxt;
      vote_r <= vote_nxt;
      shift_r <= shift_nxt;
      noise_r <= noise_nxt;
    end
  end

  // ==========================================================
  // Idle-line detection
  logic [7:0] idleCnt_r, idleCnt_nxt;
  logic [7:0] idleTicks;
  logic idleHit;

  always_comb
  begin
    idleTicks = nineBitMode ? IDLE_TICKS9 : IDLE_TICKS8;
    idleCnt_nxt = idleCnt_r;
    idleHit = 1'b0;
    if (!receiverOn)
      idleCnt_nxt = '0;
    else if (tick)
    begin
      // Any low sample clears the count; type 1 also holds it through the frame
      if (!smp || (idleCountType && state_r == ST_FRAME))
        idleCnt_nxt = '0;
      else if (idleCnt_r < idleTicks)
      begin
        idleCnt_nxt = idleCnt_r + 1'b1;
        idleHit = idleCnt_r == idleTicks - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      idleCnt_r <= '0;
    else
      idleCnt_r <= idleCnt_nxt;
  end

  // ==========================================================
  // Receive buffer, flags and clearing sequence
  asr_char_t buf_r, buf_nxt;
  asr_flags_t flags_r, flags_nxt;
  logic sleep_r, sleep_nxt;
  logic idleArm_r, idleArm_nxt;
  logic clrArm_r, clrArm_nxt;
  logic gotData_r, gotData_nxt;
  logic gotNinth_r, gotNinth_nxt;
  logic fifoReady, charMsb, parityBad, addrWake, sleeping, bufBusy, accept, clrDone;
  asr_char_t newChar;

  always_comb
  begin
    newChar.ninth = nineBitMode ? shift_r[8] : 1'b0;
    newChar.data = shift_r[7:0];
    charMsb = nineBitMode ? shift_r[8] : shift_r[7];
    parityBad = parityOn && ((^shift_r[7:0] ^ newChar.ninth) != parityOddSel);
    addrWake = frameDone && sleep_r && wakeAddrMark && charMsb;
    sleeping = sleep_r && !addrWake;
    // FIFO back-pressure counts as a full buffer
    bufBusy = flags_r.full || !fifoReady;
    accept = frameDone && !sleeping && !flags_r.framing && !bufBusy;
    buf_nxt = buf_r;
    flags_nxt = flags_r;
    sleep_nxt = sleep_r;
    idleArm_nxt = idleArm_r;
    clrArm_nxt = clrArm_r;
    gotData_nxt = gotData_r;
    gotNinth_nxt = gotNinth_r;
    clrDone = 1'b0;

    // Status read arms, data (and ninth in 9-bit mode) reads complete it
    if (statusRead && (flags_r.full || flags_r.idle))
      clrArm_nxt = 1'b1;
    if (clrArm_r && dataRead)
      gotData_nxt = 1'b1;
    if (clrArm_r && ninthRead)
      gotNinth_nxt = 1'b1;
    if (clrArm_r && gotData_nxt && (!nineBitMode || gotNinth_nxt))
    begin
      clrDone = 1'b1;
      clrArm_nxt = 1'b0;
      gotData_nxt = 1'b0;
      gotNinth_nxt = 1'b0;
      flags_nxt = '0;
    end

    // Hardware sets follow the clear so a same-cycle event wins
    if (frameDone && !sleeping && !flags_r.framing && bufBusy)
      flags_nxt.overrun = 1'b1;
    if (accept)
    begin
      buf_nxt = newChar;
      flags_nxt.full = 1'b1;
      flags_nxt.noise = noise_r;
      flags_nxt.framing = frameStopBad;
      flags_nxt.parity = parityBad;
      idleArm_nxt = 1'b1;
    end
    if (idleHit && !sleep_r && idleArm_r)
    begin
      flags_nxt.idle = 1'b1;
      idleArm_nxt = 1'b0;
    end

    if (addrWake || (idleHit && sleep_r && !wakeAddrMark))
      sleep_nxt = 1'b0;
    if (sleepWrite)
      sleep_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_r <= '0;
      flags_r <= '0;
      sleep_r <= 1'b0;
      idleArm_r <= 1'b1;
      clrArm_r <= 1'b0;
      gotData_r <= 1'b0;
      gotNinth_r <= 1'b0;
    end
    else
    begin
      buf_r <= buf_nxt;
      flags_r <= flags_nxt;
      sleep_r <= sleep_nxt;
      idleArm_r <= idleArm_nxt;
      clrArm_r <= clrArm_nxt;
      gotData_r <= gotData_nxt;
      gotNinth_r <= gotNinth_nxt;
    end
  end

  // ==========================================================
  // Transmit status flags
  logic txEmpty_r, txEmpty_nxt;
  logic txDone_r, txDone_nxt;
  logic txNinth_r, txNinth_nxt;

  always_comb
  begin
    txEmpty_nxt = txEmpty_r;
    txDone_nxt = txDone_r;
    txNinth_nxt = txNinth_r;
    if (txDataWrite)
    begin
      txEmpty_nxt = 1'b0;
      txDone_nxt = 1'b0;
    end
    if (txShiftLoad)
    begin
      txEmpty_nxt = 1'b1;
      txNinth_nxt = nineBitMode ? txNinthBit : 1'b0;
    end
    if (txLineIdle && txEmpty_r && !txDataWrite)
      txDone_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      txEmpty_r <= TX_EMPTY_RST;
      txDone_r <= TX_DONE_RST;
      txNinth_r <= 1'b0;
    end
    else
    begin
      txEmpty_r <= txEmpty_nxt;
      txDone_r <= txDone_nxt;
      txNinth_r <= txNinth_nxt;
    end
  end

  // ==========================================================
  // Character stream
  asr_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) asr_fifo_inst (
    .clk(clk),
    .rstn(rstn),
    .inValid(accept),
    .inReady(fifoReady),
    .inData(newChar),
    .outValid(streamValid),
    .outReady(streamReady),
    .outData(streamChar)
  );

  // ==========================================================
  // Outputs and requests
  assign rxChar = buf_r;
  assign rxFlags = flags_r;
  assign rxSleep = sleep_r;
  assign txEmptyFlag = txEmpty_r;
  assign txDoneFlag = txDone_r;
  assign txShiftNinth = txNinth_r;
  assign txIrq = (txEmpty_r && irqEnable.txEmpty) || (txDone_r && irqEnable.txDone);
  assign rxIrq = (flags_r.full && irqEnable.rxFull) || (flags_r.idle && irqEnable.idle);
  assign errIrq = (flags_r.overrun && irqEnable.overrun) || (flags_r.noise && irqEnable.noise)
    || (flags_r.framing && irqEnable.framing) || (flags_r.parity && irqEnable.parity);

endmodule : asr_receiver

// *** verif/asr_line_tx.sv ***
// Line model of the remote transmitter: sends one frame of up to twelve bits, first bit first.
// Assumes the bench holds the frame fields stable from request until busy falls.
`timescale 1ns/10ps
module asr_line_tx
(
  // Clock
  input wire logic clk,
  // Frame request
  input wire logic sendReq,
  input wire logic [11:0] sendBits,
  input wire logic [3:0] sendLen,
  input wire logic [7:0] bitClks,
  input wire logic [15:0] glitchAt,
  // Line
  output logic serialIn,
  output logic busy
);
  initial
  begin
    serialIn = 1'b1;
    busy = 1'b0;
  end

  // A commanded glitch flips one clock only, so the bit's majority survives
  always @(posedge clk)
  begin
    if (sendReq && !busy)
    begin
      busy <= 1'b1;
      for (int i = 0; i < bitClks * sendLen; i++)
      begin
        serialIn <= sendBits[i / bitClks] ^ (i == glitchAt);
        @(posedge clk);
      end
      serialIn <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule : asr_line_tx

// *** verif/asr_receiver_chk.sv ***
// Concurrent checks on flags, requests and transmit status of the receiver.
// Assumes it is bound onto asr_receiver; single clock domain.
`timescale 1ns/10ps
module asr_receiver_chk
  import asr_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Watched ports
  input logic wakeAddrMark,
  input logic nineBitMode,
  input asr_irq_en_t irqEnable,
  input logic statusRead,
  input logic dataRead,
  input logic txDataWrite,
  input logic txShiftLoad,
  input logic txNinthBit,
  input logic txLineIdle,
  input asr_char_t rxChar,
  input asr_flags_t rxFlags,
  input logic rxSleep,
  input logic txEmptyFlag,
  input logic txDoneFlag,
  input logic txShiftNinth,
  input logic txIrq,
  input logic rxIrq,
  input logic errIrq,
  input logic streamValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Clear sequence
  sequence s_armed;
    statusRead && !dataRead && (rxFlags.full || rxFlags.idle);
  endsequence
  sequence s_taken;
    dataRead && !statusRead && !nineBitMode;
  endsequence
  a_clear_full: assert property (s_armed ##1 s_taken |=> !rxFlags.full)
    else $error("full flag survived clear");

  // ==========================================================
  // Requests
  a_tx_group: assert property (txIrq == ((txEmptyFlag && irqEnable.txEmpty)
    || (txDoneFlag && irqEnable.txDone))) else $error("tx request wrong");
  a_rx_group: assert property (rxIrq == ((rxFlags.full && irqEnable.rxFull)
    || (rxFlags.idle && irqEnable.idle))) else $error("rx request wrong");
  a_err_group: assert property (errIrq == |(rxFlags[3:0] & irqEnable[5:2]))
    else $error("error request wrong");

  // ==========================================================
  // Receive flags
  a_err_with_full: assert property (($rose(rxFlags.noise) || $rose(rxFlags.framing)
    || $rose(rxFlags.parity)) |-> $rose(rxFlags.full)) else $error("error flag without full");
  a_ovr_keeps_buf: assert property ($rose(rxFlags.overrun) |-> $stable(rxChar)
    && !$rose(rxFlags.noise) && !$rose(rxFlags.parity)) else $error("overrun touched buffer");
  a_sleep_quiet: assert property (($rose(rxFlags.full) && !wakeAddrMark) |-> !$past(rxSleep))
    else $error("flag set while asleep");
  a_mark_wake: assert property (($fell(rxSleep) && wakeAddrMark) |-> ##[0:2]
    (rxFlags.full && (nineBitMode ? rxChar.ninth : rxChar.data[7]))) else $error("bad mark wake");
  a_stream_push: assert property ($rose(rxFlags.full) |-> ##[0:2] streamValid)
    else $error("char not streamed");

  // ==========================================================
  // Transmit flags
  a_tx_write_clr: assert property ((txDataWrite && !txShiftLoad) |=> !txEmptyFlag && !txDoneFlag)
    else $error("tx flags kept on write");
  a_shift_ninth: assert property (txShiftLoad |=> txEmptyFlag && txShiftNinth == $past(txNinthBit))
    else $error("shift load wrong");
  a_done_idle: assert property ($rose(txDoneFlag) |-> $past(txLineIdle) && $past(txEmptyFlag))
    else $error("done without idle line");
endmodule : asr_receiver_chk

bind asr_receiver asr_receiver_chk asr_receiver_chk_inst (
  .clk(clk), .rstn(rstn), .wakeAddrMark(wakeAddrMark), .nineBitMode(nineBitMode),
  .irqEnable(irqEnable), .statusRead(statusRead), .dataRead(dataRead), .txDataWrite(txDataWrite),
  .txShiftLoad(txShiftLoad), .txNinthBit(txNinthBit), .txLineIdle(txLineIdle), .rxChar(rxChar),
  .rxFlags(rxFlags), .rxSleep(rxSleep), .txEmptyFlag(txEmptyFlag), .txDoneFlag(txDoneFlag),
  .txShiftNinth(txShiftNinth), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq), .streamValid(streamValid)
);

// *** verif/tb_top.sv ***
// Self-checking bench: frames from the line model, software reads as one-cycle pulses.
// Assumes a 50 ns clock and divisor 1, except one frame at divisor 3.
`timescale 1ns/10ps
module tb_top
  import asr_pkg::*;
;
  logic clk, rstn, serialIn, receiverOn, nineBitMode, wakeAddrMark, idleCountType, parityOn, parityOddSel;
  logic statusRead, dataRead, ninthRead, sleepWrite, txDataWrite, txShiftLoad, txNinthBit, txLineIdle;
  logic streamReady, rxSleep, txEmptyFlag, txDoneFlag, txShiftNinth, txIrq, rxIrq, errIrq, streamValid;
  logic [DIV_W-1:0] baudDivisor;
  asr_irq_en_t irqEnable;
  asr_char_t rxChar, streamChar;
  asr_flags_t rxFlags;
  logic sendReq, lineBusy;
  logic [11:0] sendBits;
  logic [3:0] sendLen;
  logic [7:0] bitClks;
  logic [15:0] glitchAt;
  logic [8:0] ch;
  int mismatches, checksDone;

  asr_receiver asr_receiver_inst (
    .clk(clk), .rstn(rstn), .serialIn(serialIn), .receiverOn(receiverOn), .baudDivisor(baudDivisor),
    .nineBitMode(nineBitMode), .wakeAddrMark(wakeAddrMark), .idleCountType(idleCountType),
    .parityOn(parityOn), .parityOddSel(parityOddSel), .irqEnable(irqEnable), .statusRead(statusRead),
    .dataRead(dataRead), .ninthRead(ninthRead), .sleepWrite(sleepWrite), .txDataWrite(txDataWrite),
    .txShiftLoad(txShiftLoad), .txNinthBit(txNinthBit), .txLineIdle(txLineIdle), .rxChar(rxChar),
    .rxFlags(rxFlags), .rxSleep(rxSleep), .txEmptyFlag(txEmptyFlag), .txDoneFlag(txDoneFlag),
    .txShiftNinth(txShiftNinth), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq),
    .streamValid(streamValid), .streamReady(streamReady), .streamChar(streamChar)
  );
  asr_line_tx asr_line_tx_inst (
    .clk(clk), .sendReq(sendReq), .sendBits(sendBits), .sendLen(sendLen), .bitClks(bitClks),
    .glitchAt(glitchAt), .serialIn(serialIn), .busy(lineBusy)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Idle bit masked: it rises on its own clock once the line stays high a frame time after an accepted char
  task automatic recv(input logic [8:0] c, input logic stopb, input logic [15:0] glit,
    input logic [8:0] expChar, input logic [5:0] expFlags);
    sendBits = nineBitMode ? {1'b1, stopb, c, 1'b0} : {2'b11, stopb, c[7:0], 1'b0};
    sendLen = nineBitMode ? 4'hb : 4'ha;
    glitchAt = glit;
    sendReq = 1'b1;
    @(negedge clk);
    sendReq = 1'b0;
    for (int n = 0; n < 3000 && lineBusy !== 1'b0; n++)
      @(negedge clk);
    repeat (4) @(negedge clk);
    check(rxChar, expChar);
    check(rxFlags & 6'h2f, expFlags);
  endtask : recv

  task automatic clear_flags();
    statusRead = 1'b1;
    @(negedge clk);
    statusRead = 1'b0;
    dataRead = 1'b1;
    ninthRead = nineBitMode;
    @(negedge clk);
    dataRead = 1'b0;
    ninthRead = 1'b0;
    @(negedge clk);
  endtask : clear_flags

  // Second clear catches the idle flag that follows an accepted char
  task automatic flush();
    clear_flags();
    repeat (200) @(negedge clk);
    clear_flags();
  endtask : flush

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Sequence
  initial
  begin
    {rstn, sendReq, statusRead, dataRead, ninthRead, sleepWrite, txDataWrite, txShiftLoad} = '0;
    {txNinthBit, txLineIdle, nineBitMode, wakeAddrMark, parityOn, parityOddSel} = '0;
    {receiverOn, idleCountType, streamReady} = 3'b111;
    baudDivisor = 13'h0001;
    bitClks = 8'h10;
    irqEnable = 8'haa;
    sendBits = 12'hfff;
    sendLen = 4'ha;
    glitchAt = 16'hffff;
    mismatches = 0;
    checksDone = 0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check({rxFlags, rxSleep, txEmptyFlag, txDoneFlag, streamValid}, 10'h006);
    recv(9'h0a5, 1'b1, 16'hffff, 9'h0a5, 6'h20);
    check(rxIrq, 1'b1);
    repeat (140) @(negedge clk);
    check(rxFlags.idle, 1'b0);
    repeat (30) @(negedge clk);
    check(rxFlags.idle, 1'b1);
    recv(9'h03c, 1'b1, 16'hffff, 9'h0a5, 6'h28);
    clear_flags();
    check(rxFlags, 6'h00);
    repeat (200) @(negedge clk);
    check(rxFlags.idle, 1'b0);
    irqEnable = 8'h55;
    // Type 0 counts from the last low sample, so wake comes earlier than type 1 would allow
    idleCountType = 1'b0;
    sleepWrite = 1'b1;
    @(negedge clk);
    sleepWrite = 1'b0;
    recv(9'h077, 1'b1, 16'hffff, 9'h0a5, 6'h00);
    check(rxSleep, 1'b1);
    repeat (146) @(negedge clk);
    check(rxSleep, 1'b0);
    idleCountType = 1'b1;
    wakeAddrMark = 1'b1;
    sleepWrite = 1'b1;
    @(negedge clk);
    sleepWrite = 1'b0;
    recv(9'h015, 1'b1, 16'hffff, 9'h0a5, 6'h00);
    check(rxSleep, 1'b1);
    recv(9'h095, 1'b1, 16'hffff, 9'h095, 6'h20);
    check(rxSleep, 1'b0);
    flush();
    wakeAddrMark = 1'b0;
    recv(9'h05a, 1'b0, 16'hffff, 9'h05a, 6'h22);
    recv(9'h033, 1'b1, 16'hffff, 9'h05a, 6'h22);
    flush();
    recv(9'h0c3, 1'b1, 16'd56, 9'h0c3, 6'h24);
    flush();
    recv(9'h03c, 1'b1, 16'd8, 9'h03c, 6'h24);
    flush();
    parityOn = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      parityOddSel = p[1];
      ch = p[0] ? 9'h083 : 9'h081;
      recv(ch, 1'b1, 16'hffff, ch, {5'h10, ^ch ^ p[1]});
      flush();
    end
    parityOn = 1'b0;
    nineBitMode = 1'b1;
    recv(9'h13c, 1'b1, 16'hffff, 9'h13c, 6'h20);
    statusRead = 1'b1;
    @(negedge clk);
    statusRead = 1'b0;
    dataRead = 1'b1;
    @(negedge clk);
    dataRead = 1'b0;
    @(negedge clk);
    check(rxFlags.full, 1'b1);
    ninthRead = 1'b1;
    @(negedge clk);
    ninthRead = 1'b0;
    @(negedge clk);
    check(rxFlags.full, 1'b0);
    flush();
    nineBitMode = 1'b0;
    baudDivisor = 13'h0003;
    bitClks = 8'h30;
    recv(9'h06e, 1'b1, 16'hffff, 9'h06e, 6'h20);
    flush();
    baudDivisor = 13'h0001;
    bitClks = 8'h10;
    txDataWrite = 1'b1;
    @(negedge clk);
    txDataWrite = 1'b0;
    @(negedge clk);
    check({txEmptyFlag, txDoneFlag, txIrq}, 3'b000);
    nineBitMode = 1'b1;
    txNinthBit = 1'b1;
    txShiftLoad = 1'b1;
    @(negedge clk);
    txShiftLoad = 1'b0;
    @(negedge clk);
    check({txEmptyFlag, txDoneFlag, txShiftNinth}, 3'b101);
    txLineIdle = 1'b1;
    @(negedge clk);
    check({txDoneFlag, txIrq}, 2'b11);
    nineBitMode = 1'b0;
    // Drain stalls so the sixteen-word buffer fills and refuses the next char
    streamReady = 1'b0;
    for (int k = 0; k < 17; k++)
    begin
      ch = 9'h040 + 9'(k);
      recv(ch, 1'b1, 16'hffff, (k < 16) ? ch : 9'h04f, (k < 16) ? 6'h20 : 6'h08);
      clear_flags();
    end
    streamReady = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      check({streamValid, streamChar}, {1'b1, 9'h040 + 9'(k)});
      @(negedge clk);
    end
    check(streamValid, 1'b0);
    finish_test();
  end

  // About 8300 cycles expected; over three times that means a hang
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule : tb_top
